// ==== bench/cpk_node_model.sv ====
// far-side node model: offers a frame and holds it until acknowledged
`timescale 1ns/10ps
module cpk_node_model (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // bench request and packer answer
   input  wire logic offer,
   input  wire logic ack,
   // offered level towards the packer
   output logic      valid
);
   // offer stays up until the ack pulse, never dropped early
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         valid <= 1'b0;
      end else if (offer) begin
         valid <= 1'b1;
      end else if (ack) begin
         valid <= 1'b0;
      end
   end
endmodule : cpk_node_model

// ==== bench/tb.sv ====
// self-checking bench of the object packer
`timescale 1ns/10ps
module tb;
   import cpk_pkg::*;
   // clock, reset, register port
   logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0, regRdData, rdv;
   // frame fields, receive then transmit
   logic rxValid, rxStdIdBitTwelve = 0, rxEsi = 0, rxFdf = 0, rxBrs = 0;
   logic rxRtr = 0, rxIde = 0, txValid, txStdIdBitTwelve = 0, txEsi = 0;
   logic txFdf = 0, txBrs = 0, txRtr = 0, txIde = 0;
   logic [10:0]  rxBaseIdentifier = 0, txBaseIdentifier = 0;
   logic [17:0]  rxExtensionIdentifier = 0, txExtensionIdentifier = 0;
   logic [3:0]   rxDlc = 0, txDlc = 0;
   logic [4:0]   rxMatchedFilterIndex = 0;
   logic [22:0]  txTrackNumber = 0;
   logic [31:0]  rxCaptureStamp = 0, txCaptureStamp = 0;
   logic [511:0] rxPayload = 0;
   logic         ready, rxAck, txAck, rxOffer = 0, txOffer = 0;
   int           err_count = 0, checks_done = 0;

   always #5 clk = ~clk;

   cpk_packer u_dut (.clk, .rst, .regAddr, .regWrData, .regWr, .regRd,
      .regRdData, .rxValid, .rxBaseIdentifier, .rxExtensionIdentifier,
      .rxStdIdBitTwelve, .rxEsi, .rxFdf, .rxBrs, .rxRtr, .rxIde, .rxDlc,
      .rxMatchedFilterIndex, .rxCaptureStamp, .rxPayload, .txValid,
      .txBaseIdentifier, .txExtensionIdentifier, .txStdIdBitTwelve, .txEsi,
      .txFdf, .txBrs, .txRtr, .txIde, .txDlc, .txTrackNumber,
      .txCaptureStamp, .ready, .rxAck, .txAck);
   cpk_node_model u_rxNode (.clk, .rst, .offer(rxOffer), .ack(rxAck),
      .valid(rxValid));
   cpk_node_model u_txNode (.clk, .rst, .offer(txOffer), .ack(txAck),
      .valid(txValid));

   // verdict and end of run
   task automatic results;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // one word comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk

   // register write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1'b1; regAddr <= a; regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   // register read, data taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regRd <= 1'b1; regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rdv = regRdData;
   endtask : rd

   // object memory word compare
   task automatic rdw(input logic [4:0] w, input logic [31:0] exp);
      rd({1'b1, w, 2'b00});
      chk(rdv, exp);
   endtask : rdw

   // bounded wait on a flag, overrun ends the run
   task automatic waitFor(ref logic f);
      int i;
      for (i = 0; i < 60 && f !== 1'b1; i++) @(negedge clk);
      if (f !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED %0t handshake timeout", $time);
         results();
      end
   endtask : waitFor

   // payload byte pattern and expected payload word
   function automatic logic [7:0] pb(input int k, input int s);
      return 8'((k * 3 + s) % 256);
   endfunction : pb
   function automatic logic [31:0] pw(input int j, input int s);
      return {pb(4*j+3, s), pb(4*j+2, s), pb(4*j+1, s), pb(4*j, s)};
   endfunction : pw

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(8'h00); chk(rdv, 32'h0000_0001);
      chk({31'h0, ready}, 32'h0);
      rd(8'h0C); chk(rdv, 32'h0);
      // both stamps on, eight byte payload, then leave configuration
      wr(8'h00, 32'h0000_0007);
      wr(8'h00, 32'h0000_0006);
      waitFor(ready);
      // extended FD frame, passive sender, remote flag offered
      @(posedge clk);
      rxBaseIdentifier <= 11'h5A3; rxExtensionIdentifier <= 18'h2B4C1;
      rxStdIdBitTwelve <= 1'b1; rxEsi <= 1'b1; rxFdf <= 1'b1;
      rxBrs <= 1'b1; rxRtr <= 1'b1; rxIde <= 1'b1; rxDlc <= 4'hF;
      rxMatchedFilterIndex <= 5'h15; rxCaptureStamp <= 32'hC0DE_1234;
      for (int k = 0; k < 64; k++) rxPayload[8*k +: 8] <= pb(k, 5);
      rxOffer <= 1'b1;
      @(posedge clk);
      rxOffer <= 1'b0;
      waitFor(rxAck);
      @(posedge clk);
      waitFor(ready);
      rdw(5'h00, {2'b00, 1'b1, 18'h2B4C1, 11'h5A3});
      rdw(5'h01, {16'h0, 5'h15, 2'b00, 4'b1110, 5'h1F});
      rdw(5'h02, 32'hC0DE_1234);
      rdw(5'h03, pw(0, 5));
      rdw(5'h04, pw(1, 5));
      rd(8'h08); chk({24'h0, rdv[7:0]}, 32'h1);
      // status: five word object, rx done, then cleared by writing one
      rd(8'h04); chk(rdv, 32'h0500_0102);
      wr(8'h04, 32'h0000_0002);
      rd(8'h04); chk(rdv, 32'h0500_0100);
      // classic remote event, active sender, stamped
      @(posedge clk);
      txBaseIdentifier <= 11'h07F; txExtensionIdentifier <= 18'h00F0F;
      txStdIdBitTwelve <= 1'b0; txEsi <= 1'b0; txRtr <= 1'b1;
      txDlc <= 4'h8; txTrackNumber <= 23'h5A5A5A;
      txCaptureStamp <= 32'hFEED_BEEF;
      txOffer <= 1'b1;
      @(posedge clk);
      txOffer <= 1'b0;
      waitFor(txAck);
      @(posedge clk);
      waitFor(ready);
      rdw(5'h1C, {3'b000, 18'h00F0F, 11'h07F});
      rdw(5'h1D, {23'h5A5A5A, 1'b0, 4'b0010, 4'h8});
      rdw(5'h1E, 32'hFEED_BEEF);
      // option bits refused outside configuration
      wr(8'h00, 32'h0000_0002);
      rd(8'h00); chk(rdv, 32'h0000_0006);
      // twelve byte payload, stamps off
      wr(8'h00, 32'h0000_0011);
      repeat (2) @(negedge clk);
      chk({31'h0, ready}, 32'h0);
      wr(8'h00, 32'h0000_0010);
      waitFor(ready);
      // both sources at once, receive goes first
      @(posedge clk);
      rxFdf <= 1'b0; rxBrs <= 1'b0; rxRtr <= 1'b0; rxIde <= 1'b0;
      rxEsi <= 1'b0; rxDlc <= 4'h9; rxMatchedFilterIndex <= 5'h00;
      rxStdIdBitTwelve <= 1'b0; rxBaseIdentifier <= 11'h7FF;
      for (int k = 0; k < 64; k++) rxPayload[8*k +: 8] <= pb(k, 9);
      txEsi <= 1'b1; txFdf <= 1'b1; txBrs <= 1'b1; txRtr <= 1'b0;
      txIde <= 1'b1; txDlc <= 4'hD; txTrackNumber <= 23'h000001;
      rxOffer <= 1'b1; txOffer <= 1'b1;
      @(posedge clk);
      rxOffer <= 1'b0; txOffer <= 1'b0;
      waitFor(rxAck);
      @(posedge clk);
      waitFor(txAck);
      @(posedge clk);
      waitFor(ready);
      rdw(5'h00, {2'b00, 1'b0, 18'h2B4C1, 11'h7FF});
      rdw(5'h01, {16'h0, 5'h00, 2'b00, 4'b0000, 5'h09});
      rdw(5'h02, pw(0, 9));
      rdw(5'h03, pw(1, 9));
      rdw(5'h04, pw(2, 9));
      rdw(5'h1D, {23'h000001, 1'b1, 4'b1101, 4'hD});
      rdw(5'h1E, 32'hFEED_BEEF);
      results();
   end
endmodule : tb

// ==== inc/cpk_consts.svh ====
// constants of the receive and transmit event object packer
`ifndef CPK_CONSTS_SVH
`define CPK_CONSTS_SVH

// register offsets, byte addresses on the register port
`define CPK_ADDR_CTRL      8'h00
`define CPK_ADDR_STATUS    8'h04
`define CPK_ADDR_COUNT     8'h08
`define CPK_RAM_SEL_BIT    7

// control register fields
`define CPK_CTRL_CFG       0
`define CPK_CTRL_RXTS      1
`define CPK_CTRL_TETS      2
`define CPK_CTRL_PLS_LSB   4
`define CPK_CTRL_RESET     32'h0000_0001

// status register fields
`define CPK_STAT_BUSY      0
`define CPK_STAT_RXDONE    1
`define CPK_STAT_TXDONE    2

// object layout inside the object memory
`define CPK_RX_BASE        5'h00
`define CPK_TX_BASE        5'h1C
`define CPK_HDR_WORDS      5'h02

// object word fields
`define CPK_W0_EXT_LSB     11
`define CPK_W0_BIT12       29
`define CPK_W1_FILT_LSB    11
`define CPK_W1_TRACK_LSB   9

// payload size codes, named by payload bytes
`define CPK_PLS_8          3'h0
`define CPK_PLS_12         3'h1
`define CPK_PLS_16         3'h2
`define CPK_PLS_20         3'h3
`define CPK_PLS_24         3'h4
`define CPK_PLS_32         3'h5
`define CPK_PLS_48         3'h6

`endif

// ==== inc/cpk_pkg.sv ====
// types of the receive and transmit event object packer
package cpk_pkg;

   // packing sequence states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ID,
      ST_CTL,
      ST_STAMP,
      ST_DATA
   } cpk_state_t;

endpackage : cpk_pkg

// ==== verilog/cpk_hdr_fmt.sv ====
// builds the two header words of a receive or transmit event object
`timescale 1ns/10ps
`include "cpk_consts.svh"
module cpk_hdr_fmt
   import cpk_pkg::*;
(
   // object kind
   input  wire logic        isTx,
   // identifier
   input  wire logic [10:0] baseIdentifier,
   input  wire logic [17:0] extensionIdentifier,
   input  wire logic        stdIdBitTwelve,
   // frame flags
   input  wire logic        esi,
   input  wire logic        fdf,
   input  wire logic        brs,
   input  wire logic        rtr,
   input  wire logic        ide,
   input  wire logic [3:0]  dlc,
   // per kind fields
   input  wire logic [4:0]  matchedFilterIndex,
   input  wire logic [22:0] txTrackNumber,
   // header words
   output logic      [31:0] word0,
   output logic      [31:0] word1
);

   wire        rtrUsed = rtr & ~fdf;        // remote flag classic only
   wire [8:0]  flagBits = {esi, fdf, brs, rtrUsed, ide, dlc};
   wire [31:0] rxWord1 = {16'h0000, matchedFilterIndex, 2'b00, flagBits};
   wire [31:0] txWord1 = {txTrackNumber, flagBits};

   // identifier word, same layout for both kinds, unused top bits zero
   assign word0 = {2'b00, stdIdBitTwelve, extensionIdentifier,
                   baseIdentifier};
   // control word, filter index or track number by kind
   assign word1 = isTx ? txWord1 : rxWord1;

endmodule : cpk_hdr_fmt

// ==== verilog/cpk_obj_mem.sv ====
// object memory: one write port, one registered read port
`timescale 1ns/10ps
module cpk_obj_mem
   import cpk_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // write side, from the packer
   input  wire logic        wrEn,
   input  wire logic [4:0]  wrAddr,
   input  wire logic [31:0] wrData,
   // read side, from software
   input  wire logic        rdEn,
   input  wire logic [4:0]  rdAddr,
   output logic      [31:0] rdData
);

   logic [31:0] memArr [0:31];   // object words

   // write port, no reset on the array
   always_ff @(posedge clk) begin
      if (wrEn) begin
         memArr[wrAddr] <= wrData;
      end
   end

   // read data leave through a register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdData <= 32'h0000_0000;
      end else if (rdEn) begin
         rdData <= memArr[rdAddr];
      end
   end

endmodule : cpk_obj_mem

// ==== verilog/cpk_packer.sv ====
// packs received frames and transmit events into object memory words
//
// Contract
// - rx word0: base id 10:0, ext id 28:11
// - word0 bit 29 holds twelfth base id bit
// - rx word1 bits 15:11 hold matched filter
// - rx word1 31:16 and 10:9 carry nothing
// - rx word1 bit 8 holds error status
// - rx word1 bits 7:4 hold FDF BRS RTR IDE
// - rx word1 bits 3:0 hold data length code
// - remote flag meaningless for FD frames
// - rx time stamp written as word 2 if enabled
// - rx stamp word absent when stamping disabled
// - rx payload word count follows payload size
// - event word0 uses the same identifier layout
// - event word1 bits 31:9 hold track number
// - event word1 bit 8 holds error status
// - event word1 flags 7:4, length code 3:0
// - event stamp word 2 only when enabled
// - event stamp holds full 32-bit capture
// - track number copied from transmit object
// - sizes and stamp options change only configuring
`timescale 1ns/10ps
`include "cpk_consts.svh"
module cpk_packer
   import cpk_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // register port
   input  wire logic [7:0]   regAddr,
   input  wire logic [31:0]  regWrData,
   input  wire logic         regWr,
   input  wire logic         regRd,
   output logic      [31:0]  regRdData,
   // accepted received frame
   input  wire logic         rxValid,
   input  wire logic [10:0]  rxBaseIdentifier,
   input  wire logic [17:0]  rxExtensionIdentifier,
   input  wire logic         rxStdIdBitTwelve,
   input  wire logic         rxEsi,
   input  wire logic         rxFdf,
   input  wire logic         rxBrs,
   input  wire logic         rxRtr,
   input  wire logic         rxIde,
   input  wire logic [3:0]   rxDlc,
   input  wire logic [4:0]   rxMatchedFilterIndex,
   input  wire logic [31:0]  rxCaptureStamp,
   input  wire logic [511:0] rxPayload,
   // completed transmission
   input  wire logic         txValid,
   input  wire logic [10:0]  txBaseIdentifier,
   input  wire logic [17:0]  txExtensionIdentifier,
   input  wire logic         txStdIdBitTwelve,
   input  wire logic         txEsi,
   input  wire logic         txFdf,
   input  wire logic         txBrs,
   input  wire logic         txRtr,
   input  wire logic         txIde,
   input  wire logic [3:0]   txDlc,
   input  wire logic [22:0]  txTrackNumber,
   input  wire logic [31:0]  txCaptureStamp,
   // handshake back to the frame sources
   output logic              ready,
   output logic              rxAck,
   output logic              txAck
);

   // payload size code to number of payload words
   function automatic logic [4:0] fnPayloadWords(input logic [2:0] code);
      case (code)
         `CPK_PLS_8:  fnPayloadWords = 5'h02;
         `CPK_PLS_12: fnPayloadWords = 5'h03;
         `CPK_PLS_16: fnPayloadWords = 5'h04;
         `CPK_PLS_20: fnPayloadWords = 5'h05;
         `CPK_PLS_24: fnPayloadWords = 5'h06;
         `CPK_PLS_32: fnPayloadWords = 5'h08;
         `CPK_PLS_48: fnPayloadWords = 5'h0C;
         default:     fnPayloadWords = 5'h10;
      endcase
   endfunction : fnPayloadWords

   // control register
   logic         cfgModeFf;              // configuration mode
   logic         rxStampEnableFf;        // rx stamp word on
   logic         txEventStampEnableFf;   // event stamp word on
   logic [2:0]   payloadSizeSelectFf;    // rx payload size code
   // status and counters
   logic         rxDoneFf;               // sticky, rx object stored
   logic         txDoneFf;               // sticky, event object stored
   logic [7:0]   rxCountFf;              // rx objects stored
   logic [7:0]   txCountFf;              // event objects stored
   logic [4:0]   rxLenFf;                // words of last rx object
   // sequencing
   cpk_state_t   stateFf;                // packing state
   cpk_state_t   nxt_state;              // next packing state
   logic [4:0]   ptrFf;                  // object memory write address
   logic [3:0]   wordIdxFf;              // payload word index
   // staged frame
   logic         kindTxFf;               // object is a transmit event
   logic         stampOnFf;              // stamp word in this object
   logic [4:0]   wordsFf;                // payload words in this object
   logic [10:0]  baseIdFf;
   logic [17:0]  extIdFf;
   logic         bit12Ff;
   logic         esiFf;
   logic         fdfFf;
   logic         brsFf;
   logic         rtrFf;
   logic         ideFf;
   logic [3:0]   dlcFf;
   logic [4:0]   filtFf;
   logic [22:0]  trackFf;
   logic [31:0]  stampFf;
   logic [511:0] payloadFf;
   // register read path
   logic [31:0]  regRdFf;                // register read data
   logic         ramSelFf;               // last read hit the memory
   logic [31:0]  memRdData;              // memory read data, registered

   // header words from the staged frame
   logic [31:0]  hdrWord0;
   logic [31:0]  hdrWord1;

   // request decoding
   wire idle     = (stateFf == ST_IDLE);
   wire takeRx   = idle && ready && rxValid;
   wire takeTx   = idle && ready && txValid && !rxValid;
   wire take     = takeRx || takeTx;
   // memory write and the object end
   wire memWr    = !idle;
   wire lastData = ({1'b0, wordIdxFf} == (wordsFf - 5'h01));
   wire finish   = memWr && (nxt_state == ST_IDLE);
   wire rxFinish = finish && !kindTxFf;
   wire txFinish = finish && kindTxFf;
   // register port decoding
   wire ramHit   = regAddr[`CPK_RAM_SEL_BIT];
   wire wrCtrl   = regWr && (regAddr == `CPK_ADDR_CTRL);
   wire wrStat   = regWr && (regAddr == `CPK_ADDR_STATUS);
   wire [31:0] ctrlWord = {25'h0000000, payloadSizeSelectFf, 1'b0,
                           txEventStampEnableFf, rxStampEnableFf,
                           cfgModeFf};
   wire [31:0] statWord = {3'b000, rxLenFf, txCountFf, rxCountFf, 5'h00,
                           txDoneFf, rxDoneFf, !idle};
   wire [31:0] rdSel = (regAddr == `CPK_ADDR_CTRL)   ? ctrlWord :
                       (regAddr == `CPK_ADDR_STATUS) ? statWord :
                       (regAddr == `CPK_ADDR_COUNT)  ?
                          {16'h0000, txCountFf, rxCountFf} : 32'h0000_0000;
   // word written to the object memory
   wire [31:0] dataWord = payloadFf[{wordIdxFf, 5'h00} +: 32];
   wire [31:0] memData  = (stateFf == ST_ID)    ? hdrWord0 :
                          (stateFf == ST_CTL)   ? hdrWord1 :
                          (stateFf == ST_STAMP) ? stampFf : dataWord;

   // header formatter
   cpk_hdr_fmt u_hdr (
      .isTx                (kindTxFf),
      .baseIdentifier      (baseIdFf),
      .extensionIdentifier (extIdFf),
      .stdIdBitTwelve      (bit12Ff),
      .esi                 (esiFf),
      .fdf                 (fdfFf),
      .brs                 (brsFf),
      .rtr                 (rtrFf),
      .ide                 (ideFf),
      .dlc                 (dlcFf),
      .matchedFilterIndex  (filtFf),
      .txTrackNumber       (trackFf),
      .word0               (hdrWord0),
      .word1               (hdrWord1)
   );

   // object memory, software reads it through the register window
   cpk_obj_mem u_mem (
      .clk    (clk),
      .rst    (rst),
      .wrEn   (memWr),
      .wrAddr (ptrFf),
      .wrData (memData),
      .rdEn   (regRd && ramHit),
      .rdAddr (regAddr[6:2]),
      .rdData (memRdData)
   );

   // next state: id, control, optional stamp, payload for rx only
   always_comb begin
      nxt_state = stateFf;
      case (stateFf)
         ST_IDLE:  if (take) nxt_state = ST_ID;
         ST_ID:    nxt_state = ST_CTL;
         ST_CTL: begin
            if (stampOnFf) begin
               nxt_state = ST_STAMP;
            end else if (kindTxFf) begin
               nxt_state = ST_IDLE;
            end else begin
               nxt_state = ST_DATA;
            end
         end
         ST_STAMP: nxt_state = kindTxFf ? ST_IDLE : ST_DATA;
         ST_DATA:  if (lastData) nxt_state = ST_IDLE;
         default:  nxt_state = ST_IDLE;
      endcase
   end

   // state, pointers and handshake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stateFf   <= ST_IDLE;
         ptrFf     <= 5'h00;
         wordIdxFf <= 4'h0;
         ready     <= 1'b0;
         rxAck     <= 1'b0;
         txAck     <= 1'b0;
      end else begin
         stateFf   <= nxt_state;
         ptrFf     <= take ? (takeTx ? `CPK_TX_BASE : `CPK_RX_BASE) :
                      memWr ? ptrFf + 5'h01 : ptrFf;
         wordIdxFf <= (stateFf == ST_DATA) ? wordIdxFf + 4'h1 : 4'h0;
         ready     <= (nxt_state == ST_IDLE) && !cfgModeFf;
         rxAck     <= takeRx;
         txAck     <= takeTx;
      end
   end

   // staging of the taken frame; options frozen for the whole object
   always_ff @(posedge clk) begin
      if (take) begin
         kindTxFf  <= takeTx;
         stampOnFf <= takeTx ? txEventStampEnableFf : rxStampEnableFf;
         wordsFf   <= fnPayloadWords(payloadSizeSelectFf);
         baseIdFf  <= takeTx ? txBaseIdentifier : rxBaseIdentifier;
         extIdFf   <= takeTx ? txExtensionIdentifier : rxExtensionIdentifier;
         bit12Ff   <= takeTx ? txStdIdBitTwelve : rxStdIdBitTwelve;
         esiFf     <= takeTx ? txEsi : rxEsi;
         fdfFf     <= takeTx ? txFdf : rxFdf;
         brsFf     <= takeTx ? txBrs : rxBrs;
         rtrFf     <= takeTx ? txRtr : rxRtr;
         ideFf     <= takeTx ? txIde : rxIde;
         dlcFf     <= takeTx ? txDlc : rxDlc;
         filtFf    <= rxMatchedFilterIndex;
         trackFf   <= txTrackNumber;
         stampFf   <= takeTx ? txCaptureStamp : rxCaptureStamp;
         payloadFf <= rxPayload;
      end
   end

   // control register; object options locked outside configuration
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfgModeFf            <= 1'(`CPK_CTRL_RESET);
         rxStampEnableFf      <= 1'b0;
         txEventStampEnableFf <= 1'b0;
         payloadSizeSelectFf  <= `CPK_PLS_8;
      end else if (wrCtrl) begin
         cfgModeFf <= regWrData[`CPK_CTRL_CFG];
         if (cfgModeFf) begin
            rxStampEnableFf      <= regWrData[`CPK_CTRL_RXTS];
            txEventStampEnableFf <= regWrData[`CPK_CTRL_TETS];
            payloadSizeSelectFf  <=
               regWrData[`CPK_CTRL_PLS_LSB +: 3];
         end
      end
   end

   // status: sticky done flags, set wins over write-one-to-clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxDoneFf  <= 1'b0;
         txDoneFf  <= 1'b0;
         rxCountFf <= 8'h00;
         txCountFf <= 8'h00;
         rxLenFf   <= 5'h00;
      end else begin
         rxDoneFf  <= rxFinish ||
                      (rxDoneFf && !(wrStat && regWrData[`CPK_STAT_RXDONE]));
         txDoneFf  <= txFinish ||
                      (txDoneFf && !(wrStat && regWrData[`CPK_STAT_TXDONE]));
         rxCountFf <= rxFinish ? rxCountFf + 8'h01 : rxCountFf;
         txCountFf <= txFinish ? txCountFf + 8'h01 : txCountFf;
         if (rxFinish) begin
            rxLenFf <= `CPK_HDR_WORDS + {4'h0, stampOnFf} + wordsFf;
         end
      end
   end

   // register read data, one cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdFf  <= 32'h0000_0000;
         ramSelFf <= 1'b0;
      end else begin
         regRdFf  <= regRd ? rdSel : 32'h0000_0000;
         ramSelFf <= regRd && ramHit;
      end
   end

   // both read sources are registers; pick the one read last
   assign regRdData = ramSelFf ? memRdData : regRdFf;

   // checks on the words written into the object memory, the staged word count, the sequence end and the option lock
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_start;
      take ##1 (stateFf == ST_ID) ##1 (stateFf == ST_CTL);
   endsequence
   sequence s_noStamp;
      (stateFf == ST_CTL) && !stampOnFf;
   endsequence

   property p_word0;
      (stateFf == ST_ID) |-> (memData[10:0] == baseIdFf) &&
         (memData[28:`CPK_W0_EXT_LSB] == extIdFf) &&
         (memData[`CPK_W0_BIT12] == bit12Ff) && (memData[31:30] == 2'b00);
   endproperty
   a_word0: assert property (p_word0)
      else $error("identifier word layout wrong");

   property p_rxCtl;
      (stateFf == ST_CTL) && !kindTxFf |->
         (memData[15:`CPK_W1_FILT_LSB] == filtFf) &&
         (memData[31:16] == 16'h0000) && (memData[10:9] == 2'b00);
   endproperty
   a_rxCtl: assert property (p_rxCtl)
      else $error("rx control word filter field wrong");

   property p_flags;
      s_start |-> (memData[8:0] == {esiFf, fdfFf, brsFf,
                   rtrFf && !fdfFf, ideFf, dlcFf});
   endproperty
   a_flags: assert property (p_flags)
      else $error("control word flags wrong");

   property p_fdRemote;
      (stateFf == ST_CTL) && fdfFf |-> !memData[5];
   endproperty
   a_fdRemote: assert property (p_fdRemote)
      else $error("remote flag set on an FD frame");

   property p_stamp;
      (stateFf == ST_CTL) && stampOnFf |=>
         (stateFf == ST_STAMP) && (memData == stampFf);
   endproperty
   a_stamp: assert property (p_stamp)
      else $error("stamp word missing or wrong");

   property p_noStamp;
      s_noStamp |=> (stateFf != ST_STAMP);
   endproperty
   a_noStamp: assert property (p_noStamp)
      else $error("stamp word written while disabled");

   property p_track;
      (stateFf == ST_CTL) && kindTxFf |->
         (memData[31:`CPK_W1_TRACK_LSB] == trackFf);
   endproperty
   a_track: assert property (p_track)
      else $error("event track number wrong");

   property p_len;
      takeRx |=> (wordsFf == fnPayloadWords($past(payloadSizeSelectFf)));
   endproperty
   a_len: assert property (p_len)
      else $error("payload word count does not follow size");

   property p_lastData;
      (stateFf == ST_DATA) && lastData |=> (stateFf == ST_IDLE) &&
         (ready == !$past(cfgModeFf));
   endproperty
   a_lastData: assert property (p_lastData)
      else $error("payload did not end on its last word");

   property p_cfgLock;
      !cfgModeFf |=> $stable(payloadSizeSelectFf) &&
         $stable(rxStampEnableFf) && $stable(txEventStampEnableFf);
   endproperty
   a_cfgLock: assert property (p_cfgLock)
      else $error("object options changed outside configuration");

   property p_byteOrder;
      (stateFf == ST_DATA) |->
         (memData[7:0] == payloadFf[{wordIdxFf, 5'h00} +: 8]) &&
         (memData[31:24] == payloadFf[{wordIdxFf, 5'h18} +: 8]);
   endproperty
   a_byteOrder: assert property (p_byteOrder)
      else $error("payload byte order wrong");

endmodule : cpk_packer
